/* File: src/pdsc_defines.svh */
`ifndef PDSC_DEFINES_SVH
`define PDSC_DEFINES_SVH

// Register byte offsets on the bus.
`define PDSC_CTRL_OFS 4'h0
`define PDSC_STAT_OFS 4'h4

// Control register field positions.
`define PDSC_CTRL_CODE_LSB 0
`define PDSC_CTRL_REF_BIT  2
`define PDSC_CTRL_VCO_BIT  3
`define PDSC_CTRL_PLL_BIT  4
`define PDSC_CTRL_STOP_BIT 5
`define PDSC_CTRL_W        6

// Reference from crystal, scale by four, PLL on, running, code 00.
`define PDSC_CTRL_RESET 6'h1C

// Status register field positions.
`define PDSC_STAT_LOCK_BIT 0
`define PDSC_STAT_A_BIT    1
`define PDSC_STAT_B_BIT    2
`define PDSC_STAT_SYNC_BIT 3
`define PDSC_STAT_STOP_BIT 4
`define PDSC_STAT_REF_BIT  5

// Divider ratios with the VCO scaled by two; scaling by four doubles them.
`define PDSC_DIV_A_C0  8'h08
`define PDSC_DIV_A_C1  8'h04
`define PDSC_DIV_A_C2  8'h08
`define PDSC_DIV_A_C3  8'h04
`define PDSC_DIV_B_C0  8'h0C
`define PDSC_DIV_B_C1  8'h08
`define PDSC_DIV_B_C2  8'h14
`define PDSC_DIV_B_C3  8'h0C
`define PDSC_DIV_FB_C0 8'h30
`define PDSC_DIV_FB_C1 8'h20
`define PDSC_DIV_FB_C2 8'h50
`define PDSC_DIV_FB_C3 8'h30

// Lock monitor defaults.
`define PDSC_LOCK_TOL  16'h0001
`define PDSC_PERIOD_MAX 16'hFFFF

`endif

/* File: src/pdsc_pkg.sv */
`include "pdsc_defines.svh"

package pdsc_pkg;

    typedef struct packed {
        logic       stop;
        logic       pll_enable;
        logic       vco_scale_select;
        logic       ref_select;
        logic [1:0] divider_set_code;
    } pdsc_ctrl_s;

    typedef struct packed {
        logic [7:0] bank_a;
        logic [7:0] bank_b;
        logic [7:0] feedback;
    } pdsc_div_set_s;

    typedef enum logic {
        MON_WAIT = 1'b0,
        MON_MEAS = 1'b1
    } pdsc_mon_e;

    // Divider set for a code; every ratio doubles when the VCO is scaled by four.
    function automatic pdsc_div_set_s pdsc_div_lookup(input logic [1:0] code,
                                                     input logic       vco4);
        pdsc_div_set_s s;
        s = '0;
        unique case (code)
            2'b00: s = '{`PDSC_DIV_A_C0, `PDSC_DIV_B_C0, `PDSC_DIV_FB_C0};
            2'b01: s = '{`PDSC_DIV_A_C1, `PDSC_DIV_B_C1, `PDSC_DIV_FB_C1};
            2'b10: s = '{`PDSC_DIV_A_C2, `PDSC_DIV_B_C2, `PDSC_DIV_FB_C2};
            2'b11: s = '{`PDSC_DIV_A_C3, `PDSC_DIV_B_C3, `PDSC_DIV_FB_C3};
        endcase
        if (vco4)
        begin
            s.bank_a   = s.bank_a << 1;
            s.bank_b   = s.bank_b << 1;
            s.feedback = s.feedback << 1;
        end
        return s;
    endfunction

endpackage

/* File: src/pdsc_sync2.sv */
`timescale 1ns/1ps
`default_nettype none

module pdsc_sync2 #(
    parameter int unsigned W = 1
) (
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Asynchronous level in, synchronous level out.
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    if (W < 1)
    begin : g_bad_w
        $error("pdsc_sync2: W must be at least 1");
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule

`default_nettype wire

/* File: src/pdsc_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module pdsc_divider #(
    parameter int unsigned W = 8
) (
    // Clock and restart.
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Count enable and half period in ticks.
    input  wire logic         tick_i,
    input  wire logic [W-1:0] half_i,
    // Divided clock and its rising-edge marker.
    output logic              clk_o,
    output logic              rise_o
);

    logic [W-1:0] cnt_q;
    logic         out_q;

    if (W < 2)
    begin : g_bad_w
        $error("pdsc_divider: W must be at least 2");
    end

    // The first tick after a restart toggles high, so all dividers start aligned.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end
        else if (tick_i)
        begin
            if (cnt_q == '0)
            begin
                out_q <= ~out_q;
                cnt_q <= half_i - W'(1);
            end
            else
            begin
                cnt_q <= cnt_q - W'(1);
            end
        end
    end

    assign clk_o  = out_q;
    assign rise_o = tick_i & (cnt_q == '0) & ~out_q;

endmodule

`default_nettype wire

/* File: src/pdsc_core.sv */
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pdsc_core
    import pdsc_pkg::*;
#(
    parameter int unsigned NUM_A    = 4,
    parameter int unsigned NUM_B    = 3,
    parameter logic [15:0] LOCK_TOL = `PDSC_LOCK_TOL
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Reference clock pins.
    input  wire logic             pclk_i,
    input  wire logic             xtal_i,
    // Wishbone slave.
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // Clock outputs.
    output logic      [NUM_A-1:0] bank_a_clocks_o,
    output logic      [NUM_A-1:0] bank_a_clocks_n_o,
    output logic      [NUM_B-1:0] bank_b_clocks_o,
    output logic      [NUM_B-1:0] bank_b_clocks_n_o,
    output logic                  coincidence_flag_out_o,
    output logic                  coincidence_flag_out_n_o
);

    if (NUM_A < 1 || NUM_B < 1)
    begin : g_bad_banks
        $error("pdsc_core: each bank needs at least one output");
    end

    pdsc_ctrl_s    ctrl_q;
    pdsc_ctrl_s    ctrl_d;
    pdsc_div_set_s div_set;
    logic          cfg_change_q;
    logic          restart;
    logic [1:0]    ref_pins;
    logic          ref_level;
    logic          ref_prev_q;
    logic          ref_rise;
    logic          tick;
    logic [1:0][7:0] div_full;
    logic [1:0]    div_clk;
    logic [1:0]    div_rise;
    logic          coinc_q;
    logic          first_q;
    logic [NUM_A-1:0] bank_a_q;
    logic [NUM_A-1:0] bank_a_n_q;
    logic [NUM_B-1:0] bank_b_q;
    logic [NUM_B-1:0] bank_b_n_q;
    logic          coinc_n_q;
    logic          coinc_out_q;
    pdsc_mon_e     mon_q;
    logic [15:0]   period_q;
    logic          lock_q;
    logic [16:0]   fb_wide;
    logic [16:0]   per_wide;
    logic          in_window;
    logic          ack_q;
    logic [31:0]   rdat_q;
    logic          wr_ctrl;
    logic [1:0][7:0] gap_q;
    logic [1:0]    seen_q;

    // Register bus: one-cycle answer, write lands on the acknowledging edge.
    assign wr_ctrl = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0]
                   & (wb_adr_i == `PDSC_CTRL_OFS);
    assign ctrl_d  = pdsc_ctrl_s'(wb_dat_i[`PDSC_CTRL_W-1:0]);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            if (wb_cyc_i & wb_stb_i & ~ack_q)
            begin
                unique case (wb_adr_i)
                    `PDSC_CTRL_OFS: rdat_q <= {26'h000_0000, ctrl_q};
                    `PDSC_STAT_OFS: rdat_q <= {26'h000_0000, ref_level, restart,
                                               coinc_q, div_clk[1], div_clk[0], lock_q};
                    default:        rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= pdsc_ctrl_s'(`PDSC_CTRL_RESET);
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // A change of selection restarts all dividers so the banks realign.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_change_q <= 1'b0;
        end
        else
        begin
            cfg_change_q <= wr_ctrl & (ctrl_d[`PDSC_CTRL_PLL_BIT:0]
                                       != ctrl_q[`PDSC_CTRL_PLL_BIT:0]);
        end
    end

    assign restart = rst_i | ctrl_q.stop | cfg_change_q;

    // Reference pins are asynchronous and pass two flip-flops first.
    pdsc_sync2 #(
        .W (2)
    ) u_ref_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({xtal_i, pclk_i}),
        .q_o   (ref_pins)
    );

    assign ref_level = ctrl_q.ref_select ? ref_pins[1] : ref_pins[0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ref_prev_q <= 1'b0;
        end
        else
        begin
            ref_prev_q <= ref_level;
        end
    end

    assign ref_rise = ref_level & ~ref_prev_q;

    // The system clock stands for the VCO; in bypass the reference replaces it.
    assign tick    = ctrl_q.pll_enable ? 1'b1 : ref_rise;
    assign div_set = pdsc_div_lookup(ctrl_q.divider_set_code,
                                     ctrl_q.vco_scale_select);
    assign div_full[0] = div_set.bank_a;
    assign div_full[1] = div_set.bank_b;

    for (genvar i = 0; i < 2; i++)
    begin : g_bank_div
        pdsc_divider #(
            .W (8)
        ) u_div (
            .clk_i  (clk_i),
            .rst_i  (restart),
            .tick_i (tick),
            .half_i ({1'b0, div_full[i][7:1]}),
            .clk_o  (div_clk[i]),
            .rise_o (div_rise[i])
        );
    end

    // Sync flag holds from one coincident rising edge until the next tick.
    always_ff @(posedge clk_i)
    begin
        if (restart)
        begin
            coinc_q <= 1'b0;
        end
        else if (tick)
        begin
            coinc_q <= div_rise[0] & div_rise[1];
        end
    end

    // Outputs stop low while held; the flag is delayed with the banks to mark their edges.
    always_ff @(posedge clk_i)
    begin
        if (restart)
        begin
            bank_a_q   <= '0;
            bank_a_n_q <= '1;
            bank_b_q   <= '0;
            bank_b_n_q <= '1;
            coinc_out_q <= 1'b0;
            coinc_n_q  <= 1'b1;
        end
        else
        begin
            bank_a_q   <= {NUM_A{div_clk[0]}};
            bank_a_n_q <= {NUM_A{~div_clk[0]}};
            bank_b_q   <= {NUM_B{div_clk[1]}};
            bank_b_n_q <= {NUM_B{~div_clk[1]}};
            coinc_out_q <= coinc_q;
            coinc_n_q  <= ~coinc_q;
        end
    end

    assign bank_a_clocks_o          = bank_a_q;
    assign bank_a_clocks_n_o        = bank_a_n_q;
    assign bank_b_clocks_o          = bank_b_q;
    assign bank_b_clocks_n_o        = bank_b_n_q;
    assign coincidence_flag_out_o   = coinc_out_q;
    assign coincidence_flag_out_n_o = coinc_n_q;

    // Lock monitor: VCO cycles per reference period must match the feedback ratio.
    assign fb_wide   = {9'h000, div_set.feedback};
    assign per_wide  = {1'b0, period_q};
    assign in_window = (per_wide + {1'b0, LOCK_TOL} >= fb_wide)
                     & (per_wide <= fb_wide + {1'b0, LOCK_TOL});

    always_ff @(posedge clk_i)
    begin
        if (restart)
        begin
            mon_q    <= MON_WAIT;
            period_q <= 16'h0000;
            lock_q   <= 1'b0;
        end
        else if (ref_rise)
        begin
            period_q <= 16'h0001;
            mon_q    <= MON_MEAS;
            if (mon_q == MON_MEAS)
            begin
                lock_q <= ctrl_q.pll_enable & in_window;
            end
        end
        else if (period_q == `PDSC_PERIOD_MAX)
        begin
            // Reference lost: lock drops until the reference returns and a full period is measured again.
            mon_q  <= MON_WAIT;
            lock_q <= 1'b0;
        end
        else
        begin
            period_q <= period_q + 16'h0001;
        end
    end

    // Helper logic for the checks below.
    always_ff @(posedge clk_i)
    begin
        if (restart)
        begin
            first_q <= 1'b1;
            gap_q   <= '0;
            seen_q  <= 2'b00;
        end
        else if (tick)
        begin
            first_q <= 1'b0;
            for (int i = 0; i < 2; i++)
            begin
                if (div_rise[i])
                begin
                    gap_q[i]  <= 8'h01;
                    seen_q[i] <= 1'b1;
                end
                else
                begin
                    gap_q[i] <= gap_q[i] + 8'h01;
                end
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking

    default disable iff (rst_i);

    AST_REF_SELECT:
    assert property (ref_level == (ctrl_q.ref_select ? ref_pins[1] : ref_pins[0]))
        else $error("selected reference does not follow the select bit");

    AST_BYPASS_TICK:
    assert property (!ctrl_q.pll_enable |-> (tick == ref_rise))
        else $error("bypass does not advance on reference edges");

    AST_BYPASS_DIVIDES:
    assert property (!ctrl_q.pll_enable && !tick && !restart |=> $stable(div_clk))
        else $error("dividers moved without a reference edge in bypass");

    AST_STOP_LOW:
    assert property (restart |=> bank_a_clocks_o == '0 && bank_b_clocks_o == '0
                     && &bank_a_clocks_n_o && &bank_b_clocks_n_o
                     && !coincidence_flag_out_o && coincidence_flag_out_n_o)
        else $error("outputs not stopped low during stop");

    AST_SYNC_SET:
    assert property (tick && div_rise[0] && div_rise[1] && !restart ##1 !restart
                     |=> coincidence_flag_out_o)
        else $error("coincident edge not flagged");

    AST_SYNC_CAUSE:
    assert property ($rose(coincidence_flag_out_o) |-> $past(div_rise[0] && div_rise[1], 2))
        else $error("sync flag without coincident edges");

    AST_A_PERIOD_X2:
    assert property (tick && div_rise[0] && seen_q[0] && !restart && $stable(div_set)
                     && !ctrl_q.vco_scale_select |-> gap_q[0] == div_set.bank_a)
        else $error("bank A period wrong with scale by two");

    AST_B_PERIOD_X4:
    assert property (tick && div_rise[1] && seen_q[1] && !restart && $stable(div_set)
                     && ctrl_q.vco_scale_select |-> gap_q[1] == div_set.bank_b)
        else $error("bank B period wrong with scale by four");

    AST_B_FOUR_REF:
    assert property ({div_set.bank_b, 2'b00} == {2'b00, div_set.feedback})
        else $error("bank B is not four times the reference");

    AST_COMPLEMENT:
    assert property (bank_a_clocks_n_o == ~bank_a_clocks_o
                     && bank_b_clocks_n_o == ~bank_b_clocks_o)
        else $error("complement outputs disagree");

    AST_LOCK_CAUSE:
    assert property ($rose(lock_q) |-> $past(ref_rise && in_window && ctrl_q.pll_enable))
        else $error("lock set without matching reference period");

    AST_ALIGN:
    assert property (first_q && tick && !restart |-> div_rise[0] && div_rise[1])
        else $error("banks do not start from a common edge");

    AST_WB_ACK_ONE:
    assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge held longer than one cycle");

    COV_SYNC:   cover property (coincidence_flag_out_o);
    COV_LOCK:   cover property ($rose(lock_q));
    COV_BYPASS: cover property (!ctrl_q.pll_enable && div_rise[0]);
    COV_STOP:   cover property (ctrl_q.stop ##1 !ctrl_q.stop);

endmodule

`default_nettype wire

/* File: verification/pdsc_ref_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Free-running reference sources on the board: the differential input and the crystal.
// Half periods may change at any time; the new value applies at once, to the half period in progress.
module pdsc_ref_model (
    // Clock.
    input  wire logic       clk_i,
    // Half periods of the two references in clock cycles.
    input  wire logic [7:0] pclk_half_i,
    input  wire logic [7:0] xtal_half_i,
    // Reference clock levels.
    output logic            pclk_o,
    output logic            xtal_o
);
    logic [7:0] pcnt_q = 8'h00;
    logic [7:0] xcnt_q = 8'h00;
    logic       pclk_q = 1'b0;
    logic       xtal_q = 1'b0;

    always_ff @(posedge clk_i)
    begin
        if (pcnt_q >= pclk_half_i - 8'h01)
        begin
            pcnt_q <= 8'h00;
            pclk_q <= ~pclk_q;
        end
        else
            pcnt_q <= pcnt_q + 8'h01;
    end

    always_ff @(posedge clk_i)
    begin
        if (xcnt_q >= xtal_half_i - 8'h01)
        begin
            xcnt_q <= 8'h00;
            xtal_q <= ~xtal_q;
        end
        else
            xcnt_q <= xcnt_q + 8'h01;
    end

    assign pclk_o = pclk_q;
    assign xtal_o = xtal_q;
endmodule

`default_nettype wire

/* File: verification/pll_divider_sync_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH %0t %s", $time, m); end end

module pll_divider_sync_control_tb_top;
    localparam int LIMIT = 60000;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        pclk_i;
    logic        xtal_i;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [3:0]  bank_a_clocks_o;
    logic [3:0]  bank_a_clocks_n_o;
    logic [2:0]  bank_b_clocks_o;
    logic [2:0]  bank_b_clocks_n_o;
    logic        coincidence_flag_out_o;
    logic        coincidence_flag_out_n_o;
    logic [7:0]  pclk_half = 8'h03;
    logic [7:0]  xtal_half = 8'h05;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          div_a[4] = '{8, 4, 8, 4};
    int          div_b[4] = '{12, 8, 20, 12};

    always #5 clk_i = ~clk_i;

    pdsc_ref_model u_ref (
        .clk_i       (clk_i),
        .pclk_half_i (pclk_half),
        .xtal_half_i (xtal_half),
        .pclk_o      (pclk_i),
        .xtal_o      (xtal_i)
    );

    pdsc_core DUT (
        .clk_i                    (clk_i),
        .rst_i                    (rst_i),
        .pclk_i                   (pclk_i),
        .xtal_i                   (xtal_i),
        .wb_cyc_i                 (wb_cyc_i),
        .wb_stb_i                 (wb_stb_i),
        .wb_we_i                  (wb_we_i),
        .wb_adr_i                 (wb_adr_i),
        .wb_sel_i                 (wb_sel_i),
        .wb_dat_i                 (wb_dat_i),
        .wb_dat_o                 (wb_dat_o),
        .wb_ack_o                 (wb_ack_o),
        .bank_a_clocks_o          (bank_a_clocks_o),
        .bank_a_clocks_n_o        (bank_a_clocks_n_o),
        .bank_b_clocks_o          (bank_b_clocks_o),
        .bank_b_clocks_n_o        (bank_b_clocks_n_o),
        .coincidence_flag_out_o   (coincidence_flag_out_o),
        .coincidence_flag_out_n_o (coincidence_flag_out_n_o)
    );

    task automatic give_verdict();
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            num_errors++;
            give_verdict();
        end
    end

    // Every output of a bank follows one divider, and each complement mirrors its true side.
    always @(negedge clk_i)
    begin
        `CHK(bank_a_clocks_o, {4{bank_a_clocks_o[0]}}, "bank A outputs differ")
        `CHK(bank_b_clocks_o, {3{bank_b_clocks_o[0]}}, "bank B outputs differ")
        `CHK({bank_a_clocks_n_o, bank_b_clocks_n_o}, ~{bank_a_clocks_o, bank_b_clocks_o}, "pair")
        `CHK(coincidence_flag_out_n_o, ~coincidence_flag_out_o, "flag pair")
    end

    // One classic single cycle; the answer is taken at the edge where ack is seen high.
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                           output logic [31:0] rd);
        int g;
        g = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && g < 100)
        begin
            @(posedge clk_i);
            g++;
        end
        `CHK(wb_ack_o, 1'b1, "no bus acknowledge")
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return bank_a_clocks_o[0];
            1: return bank_b_clocks_o[0];
            default: return coincidence_flag_out_o;
        endcase
    endfunction

    task automatic to_rise(input int k, inout int p);
        int g;
        g = 0;
        while (sig(k) !== 1'b0 && g < 2000)
        begin
            @(negedge clk_i);
            p++;
            g++;
        end
        while (sig(k) !== 1'b1 && g < 2000)
        begin
            @(negedge clk_i);
            p++;
            g++;
        end
    endtask

    task automatic period(input int k, output int p);
        // A changed setup restarts the dividers one cycle after the write; let it pass.
        repeat (3) @(posedge clk_i);
        p = 0;
        to_rise(k, p);
        p = 0;
        to_rise(k, p);
    endtask

    function automatic int lcm(input int x, input int y);
        int a;
        int b;
        int t;
        a = x;
        b = y;
        while (b != 0)
        begin
            t = a % b;
            a = b;
            b = t;
        end
        return x / a * y;
    endfunction

    task automatic chk_stopped();
        `CHK({bank_a_clocks_o, bank_b_clocks_o, coincidence_flag_out_o}, 8'h00, "not low")
        `CHK({bank_a_clocks_n_o, bank_b_clocks_n_o, coincidence_flag_out_n_o}, 8'hFF, "n")
    endtask

    initial
    begin
        int          p;
        int          g;
        logic [31:0] rd;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk_stopped();
        @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, 4'h0, 32'h0, rd);
        `CHK(rd[2], 1'b1, "crystal not default")
        `CHK(rd[3], 1'b1, "scale by four not default")
        `CHK(rd[4], 1'b1, "PLL not enabled by default")
        `CHK(rd[5], 1'b0, "stop set by default")
        wb_xfer(1'b0, 4'h8, 32'h0, rd);
        `CHK(rd, 32'h0000_0000, "unmapped read not zero")
        // Start-up stop pulse, held longer than one crystal period.
        wb_xfer(1'b1, 4'h0, 32'h3C, rd);
        @(posedge clk_i);
        repeat (14)
        begin
            @(negedge clk_i);
            chk_stopped();
        end
        wb_xfer(1'b0, 4'h4, 32'h0, rd);
        `CHK(rd[4], 1'b1, "restart not shown in status")
        wb_xfer(1'b1, 4'h0, 32'h1C, rd);
        g = 0;
        while (bank_a_clocks_o[0] !== 1'b1 && g < 100)
        begin
            @(negedge clk_i);
            g++;
        end
        `CHK(bank_b_clocks_o[0], 1'b1, "banks not aligned on release")
        `CHK(coincidence_flag_out_o, 1'b1, "no flag on first edge")
        for (int v = 0; v < 2; v++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                wb_xfer(1'b1, 4'h0, 32'h14 | (v << 3) | c, rd);
                period(0, p);
                `CHK(p, div_a[c] << v, "bank A period")
                period(1, p);
                `CHK(p, div_b[c] << v, "bank B period")
                period(2, p);
                `CHK(p, lcm(div_a[c], div_b[c]) << v, "flag period")
            end
        end
        // Bypass with code 01 and scale by two: bank A divides by 4, bank B by 8.
        wb_xfer(1'b1, 4'h0, 32'h01, rd);
        period(0, p);
        `CHK(p, 4 * 6, "bypass bank A on differential input")
        period(1, p);
        `CHK(p, 8 * 6, "bypass bank B on differential input")
        wb_xfer(1'b1, 4'h0, 32'h05, rd);
        period(0, p);
        `CHK(p, 4 * 10, "bypass bank A on crystal")
        // Reference period of 32 cycles matches feedback 32 but not 48.
        pclk_half <= 8'h10;
        wb_xfer(1'b1, 4'h0, 32'h11, rd);
        repeat (300) @(posedge clk_i);
        wb_xfer(1'b0, 4'h4, 32'h0, rd);
        `CHK(rd[0], 1'b1, "no lock with matching feedback")
        wb_xfer(1'b1, 4'h0, 32'h10, rd);
        repeat (300) @(posedge clk_i);
        wb_xfer(1'b0, 4'h4, 32'h0, rd);
        `CHK(rd[0], 1'b0, "lock with wrong feedback")
        give_verdict();
    end
endmodule

`default_nettype wire
